// [src/spc_map.svh]
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// i/o addresses
`define SPC_A_CTRL 16'hFB98
`define SPC_A_SYNTH 16'hFB99
`define SPC_A_TIMING 16'hFB9A
`define SPC_A_MODE 16'hFB9B
`define SPC_A_CNT0 16'hFB9C
`define SPC_A_CNT1 16'hFB9D
`define SPC_A_CNT2 16'hFB9E
`define SPC_A_SETUP 16'hFB9F
`define SPC_A_SHIFT 16'hFF98
`define SPC_A_GATE 16'hFF9F

// port direction mode words
`define SPC_MODE_NORMAL 8'h81
`define SPC_MODE_STATUS 8'h83
`define SPC_MODE_SET_BIT 7
`define SPC_MODE_B_IN_BIT 1
`define SPC_BSR_UPPER_BIT 3
`define SPC_BSR_IDX_HI 2
`define SPC_BSR_IDX_LO 1
`define SPC_BSR_VAL_BIT 0

// control output port fields
`define SPC_BG_BIT 7
`define SPC_PAGE_HI 3
`define SPC_PAGE_LO 2
`define SPC_SRC_HI 1
`define SPC_SRC_LO 0
`define SPC_SRC_TEST 2'h2

// timing port fields, upper nibble held in a 4-bit latch
`define SPC_UP_DIR 2
`define SPC_UP_WS 1
`define SPC_UP_RS 0

// audio gating latch fields
`define SPC_IE_BIT 1
`define SPC_CHEN_BIT 0

// counter setup word encodings
`define SPC_SEL_READBACK 2'h3
`define SPC_RW_LATCH 2'h0
`define SPC_RW_LSB 2'h1
`define SPC_RW_MSB 2'h2
`define SPC_RW_BOTH 2'h3
`define SPC_TM_SQUARE 2'h3

// counter constants
`define SPC_FULL_COUNT 17'h10000
`define SPC_COUNT_ONE 17'h00001
`define SPC_CH_NUM 3

`endif

// [src/spc_pkg.sv]
package spc_pkg;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } spc_io_req_t;

   typedef struct packed {
      logic [1:0] sel;
      logic [1:0] rw;
      logic [2:0] mode;
      logic bcd;
   } spc_setup_t;

   typedef enum logic [0:0] {
      SPC_WR_LO = 1'b0,
      SPC_WR_HI = 1'b1
   } spc_wr_state_t;

endpackage

// [src/spc_timer_ch.sv]
`timescale 1ns/1ns
`include "spc_map.svh"

module spc_timer_ch (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cnt_en,
   input wire logic gate,
   input wire logic setup_wr,
   input spc_pkg::spc_setup_t setup,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic out
);
   import spc_pkg::*;

   spc_setup_t cfg_r;
   spc_wr_state_t wr_st_r;
   logic [15:0] div_r;
   logic [15:0] hold_r;
   logic armed_r;
   logic load_r;
   logic held_r;
   logic rd_hi_r;
   logic gate_d_r;
   logic out_r;
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic [16:0] step;
   logic [16:0] reload;
   logic cfg_wr;
   logic div_done;
   logic square;
   logic [15:0] rd_src;

   assign cfg_wr = setup_wr && (setup.rw != `SPC_RW_LATCH);
   assign div_done = data_wr && (cfg_r.rw != `SPC_RW_LATCH) &&
                     ((cfg_r.rw != `SPC_RW_BOTH) || (wr_st_r == SPC_WR_HI));
   assign square = (cfg_r.mode[1:0] == `SPC_TM_SQUARE);
   // a divisor of zero means the full 16-bit span
   assign reload = (div_r == 16'h0000) ? `SPC_FULL_COUNT : {1'b0, div_r};
   assign cnt_nxt = (cnt_r <= `SPC_COUNT_ONE) ? reload : cnt_r - `SPC_COUNT_ONE;
   assign step = load_r ? reload : cnt_nxt;
   assign out = out_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= '0;
         wr_st_r <= SPC_WR_LO;
         div_r <= 16'h0000;
         armed_r <= 1'b0;
      end else if (cfg_wr) begin
         cfg_r <= setup;
         wr_st_r <= SPC_WR_LO;
         armed_r <= 1'b0;
      end else if (data_wr) begin
         case (cfg_r.rw)
            `SPC_RW_LSB: begin
               div_r <= {8'h00, wdata};
               armed_r <= 1'b1;
            end
            `SPC_RW_MSB: begin
               div_r <= {wdata, 8'h00};
               armed_r <= 1'b1;
            end
            `SPC_RW_BOTH: begin
               if (wr_st_r == SPC_WR_LO) begin
                  div_r[7:0] <= wdata;
                  wr_st_r <= SPC_WR_HI;
                  armed_r <= 1'b0;
               end else begin
                  div_r[15:8] <= wdata;
                  wr_st_r <= SPC_WR_LO;
                  armed_r <= 1'b1;
               end
            end
            default: begin
               armed_r <= armed_r;
            end
         endcase
      end
   end

   // new divisor or a rising gate restarts the count on the next count edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 17'h00000;
         load_r <= 1'b0;
         gate_d_r <= 1'b0;
      end else begin
         gate_d_r <= gate;
         if (cfg_wr) begin
            load_r <= 1'b0;
         end else if (div_done || (gate && !gate_d_r)) begin
            load_r <= 1'b1;
         end else if (cnt_en && gate && armed_r) begin
            cnt_r <= step;
            load_r <= 1'b0;
         end
      end
   end

   // rate mode: low for the count of one; square mode: high for the upper half
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_r <= 1'b1;
      end else if (cfg_wr || !gate) begin
         out_r <= 1'b1;
      end else if (cnt_en && armed_r && !div_done) begin
         if (square) begin
            out_r <= (step > (reload >> 1));
         end else begin
            out_r <= (step != `SPC_COUNT_ONE);
         end
      end
   end

   assign rd_src = held_r ? hold_r : cnt_r[15:0];
   assign rdata = ((cfg_r.rw == `SPC_RW_MSB) ||
                   ((cfg_r.rw == `SPC_RW_BOTH) && rd_hi_r)) ? rd_src[15:8] : rd_src[7:0];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_r <= 16'h0000;
         held_r <= 1'b0;
         rd_hi_r <= 1'b0;
      end else if (cfg_wr) begin
         held_r <= 1'b0;
         rd_hi_r <= 1'b0;
      end else if (setup_wr && !held_r) begin
         hold_r <= cnt_r[15:0];
         held_r <= 1'b1;
      end else if (data_rd) begin
         if (cfg_r.rw == `SPC_RW_BOTH) begin
            rd_hi_r <= !rd_hi_r;
            if (rd_hi_r) begin
               held_r <= 1'b0;
            end
         end else begin
            held_r <= 1'b0;
         end
      end
   end

endmodule

// [src/spc_shift.sv]
`timescale 1ns/1ns

module spc_shift (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [7:0] din,
   input wire logic shift_en,
   input wire logic encode,
   input wire logic ser_in,
   output logic [7:0] q,
   output logic ser_out
);
   logic [7:0] sr_r;

   // a host write wins over a shift in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sr_r <= 8'h00;
      end else if (load) begin
         sr_r <= din;
      end else if (shift_en) begin
         sr_r <= {sr_r[6:0], encode ? ser_in : 1'b0};
      end
   end

   assign q = sr_r;
   assign ser_out = sr_r[7];

endmodule

// [src/spc_top.sv]
// Functional notes
// - mode sets synth data port direction
// - mode write clears all port outputs
// - control bit 7 flags background synthesis
// - control bits 3-2 select ROM page
// - control bits 1-0 select audio source
// - synth port writes data, reads status bits
// - timing bit 6 picks decode or encode
// - timing bits 5,4 drive write/read strobes
// - timing bit 3 reads inverted bit clock
// - timing bit 2 reads byte frame level
// - timing bit 1 reads active-low interrupt
// - timing bit 0 reads synthesizer busy
// - counters 0 and 2 run from system clock
// - counter 0 square wave, gate held active
// - shift on inverted bit clock rising edge
// - inverted counter 0 output clocks counter 1
// - counter 1 divides by 8, frame pulse
// - interrupt enable steers counter 2 output
// - counter 2 gate active while interrupt or channel enabled
// - shift register serialises both ways, drives when read
// - latch bit 1 interrupt enable, reads inverted
// - latch bit 0 enables audio channel output
`timescale 1ns/1ns
`include "spc_map.svh"

module spc_top (
   input wire logic clk,
   input wire logic reset_n,
   input spc_pkg::spc_io_req_t io_req,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe_n,
   input wire logic [7:0] synth_data_in,
   output logic [7:0] synth_data_out,
   output logic synth_data_oe_n,
   output logic synth_write_strobe,
   output logic synth_read_strobe,
   input wire logic synth_interrupt_n,
   input wire logic synth_busy_flag,
   output logic codec_direction_select,
   output logic codec_bit_clock,
   output logic codec_byte_frame,
   output logic codec_serial_out,
   input wire logic codec_serial_in,
   output logic background_flag,
   output logic [1:0] rom_page,
   output logic [1:0] audio_source_select,
   output logic audio_channel_enable,
   output logic synth_irq_tick,
   output logic audio_test_tone
);
   import spc_pkg::*;

   // port interface latches
   logic [7:0] ctrl_r;
   logic [7:0] synth_out_r;
   logic [3:0] upper_r;
   logic synth_in_mode_r;

   // audio gating latch
   logic irq_en_r;
   logic chan_en_r;

   // read answer
   logic [7:0] rdata_r;
   logic drive_r;
   logic [7:0] rd_mux;
   logic rd_hit;

   // counters
   logic [2:0] ch_out;
   logic [2:0] ch_en;
   logic [2:0] ch_gate;
   logic [2:0] ch_setup_wr;
   logic [2:0] ch_data_wr;
   logic [2:0] ch_data_rd;
   logic [7:0] ch_rdata [0:2];
   logic [15:0] ch_addr [0:2];
   spc_setup_t setup_word;
   logic bclk_d_r;
   logic bclk_fall;

   // shift register
   logic [7:0] shift_q;
   logic shift_load;

   logic wr_ctrl;
   logic wr_synth;
   logic wr_mode;
   logic wr_setup;
   logic wr_gate;
   logic mode_set;

   assign wr_ctrl = io_req.wr && (io_req.addr == `SPC_A_CTRL);
   assign wr_synth = io_req.wr && (io_req.addr == `SPC_A_SYNTH);
   assign wr_mode = io_req.wr && (io_req.addr == `SPC_A_MODE);
   assign wr_setup = io_req.wr && (io_req.addr == `SPC_A_SETUP);
   assign wr_gate = io_req.wr && (io_req.addr == `SPC_A_GATE);
   assign shift_load = io_req.wr && (io_req.addr == `SPC_A_SHIFT);
   assign mode_set = wr_mode && io_req.wdata[`SPC_MODE_SET_BIT];
   assign setup_word = spc_setup_t'(io_req.wdata);

   // control output port; a mode word wipes it, so page drops back to 0
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= 8'h00;
      end else if (mode_set) begin
         ctrl_r <= 8'h00;
      end else if (wr_ctrl) begin
         ctrl_r <= io_req.wdata;
      end
   end

   assign background_flag = ctrl_r[`SPC_BG_BIT];
   assign rom_page = ctrl_r[`SPC_PAGE_HI:`SPC_PAGE_LO];
   assign audio_source_select = ctrl_r[`SPC_SRC_HI:`SPC_SRC_LO];

   // synth data port direction follows the port B input bit of the mode word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         synth_in_mode_r <= 1'b1;
      end else if (mode_set) begin
         synth_in_mode_r <= io_req.wdata[`SPC_MODE_B_IN_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         synth_out_r <= 8'h00;
      end else if (mode_set) begin
         synth_out_r <= 8'h00;
      end else if (wr_synth) begin
         synth_out_r <= io_req.wdata;
      end
   end

   assign synth_data_out = synth_out_r;
   assign synth_data_oe_n = synth_in_mode_r;

   // upper timing nibble: cleared by a mode word, or single bits set/reset
   // by a mode-register write with the set flag clear
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_upper
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               upper_r[gi] <= 1'b0;
            end else if (mode_set) begin
               upper_r[gi] <= 1'b0;
            end else if (wr_mode && io_req.wdata[`SPC_BSR_UPPER_BIT] &&
                         (io_req.wdata[`SPC_BSR_IDX_HI:`SPC_BSR_IDX_LO] == 2'(gi))) begin
               upper_r[gi] <= io_req.wdata[`SPC_BSR_VAL_BIT];
            end else if (io_req.wr && (io_req.addr == `SPC_A_TIMING)) begin
               upper_r[gi] <= io_req.wdata[gi + 4];
            end
         end
      end
   endgenerate

   assign codec_direction_select = upper_r[`SPC_UP_DIR];
   assign synth_write_strobe = upper_r[`SPC_UP_WS];
   assign synth_read_strobe = upper_r[`SPC_UP_RS];

   // audio gating latch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_en_r <= 1'b0;
         chan_en_r <= 1'b0;
      end else if (wr_gate) begin
         irq_en_r <= io_req.wdata[`SPC_IE_BIT];
         chan_en_r <= io_req.wdata[`SPC_CHEN_BIT];
      end
   end

   assign audio_channel_enable = chan_en_r;

   // counter clocking: 0 and 2 count every system clock, 1 counts on the
   // rising edge of the inverted counter 0 output
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bclk_d_r <= 1'b1;
      end else begin
         bclk_d_r <= ch_out[0];
      end
   end

   assign bclk_fall = bclk_d_r && !ch_out[0];
   assign ch_en = {1'b1, bclk_fall, 1'b1};
   // counter 2 gate held while either of its uses is selected
   assign ch_gate = {irq_en_r || chan_en_r, 1'b1, 1'b1};
   assign ch_addr[0] = `SPC_A_CNT0;
   assign ch_addr[1] = `SPC_A_CNT1;
   assign ch_addr[2] = `SPC_A_CNT2;

   genvar ci;
   generate
      for (ci = 0; ci < `SPC_CH_NUM; ci = ci + 1) begin : g_ch
         assign ch_setup_wr[ci] = wr_setup && (setup_word.sel == 2'(ci)) &&
                                  (setup_word.sel != `SPC_SEL_READBACK);
         assign ch_data_wr[ci] = io_req.wr && (io_req.addr == ch_addr[ci]);
         assign ch_data_rd[ci] = io_req.rd && (io_req.addr == ch_addr[ci]);
         spc_timer_ch u_ch (
            .clk(clk),
            .reset_n(reset_n),
            .cnt_en(ch_en[ci]),
            .gate(ch_gate[ci]),
            .setup_wr(ch_setup_wr[ci]),
            .setup(setup_word),
            .data_wr(ch_data_wr[ci]),
            .data_rd(ch_data_rd[ci]),
            .wdata(io_req.wdata),
            .rdata(ch_rdata[ci]),
            .out(ch_out[ci])
         );
      end
   endgenerate

   assign codec_bit_clock = ch_out[0];
   assign codec_byte_frame = ch_out[1];

   // counter 2 either ticks the host interrupt or feeds the audio test source
   assign synth_irq_tick = irq_en_r && ch_out[2];
   assign audio_test_tone = !irq_en_r && chan_en_r && ch_out[2] &&
                            (ctrl_r[`SPC_SRC_HI:`SPC_SRC_LO] == `SPC_SRC_TEST);

   // serial data changes on the bit clock fall, so the codec samples a
   // settled bit on the following rise
   spc_shift u_shift (
      .clk(clk),
      .reset_n(reset_n),
      .load(shift_load),
      .din(io_req.wdata),
      .shift_en(bclk_fall),
      .encode(upper_r[`SPC_UP_DIR]),
      .ser_in(codec_serial_in),
      .q(shift_q),
      .ser_out(codec_serial_out)
   );

   // read decode; write-only ports read back their latches
   always_comb begin
      rd_mux = 8'h00;
      rd_hit = 1'b1;
      case (io_req.addr)
         `SPC_A_CTRL: begin
            rd_mux = ctrl_r;
         end
         `SPC_A_SYNTH: begin
            rd_mux = synth_in_mode_r ? synth_data_in : synth_out_r;
         end
         `SPC_A_TIMING: begin
            rd_mux = {upper_r, !ch_out[0], ch_out[1],
                      synth_interrupt_n, synth_busy_flag};
         end
         `SPC_A_CNT0: begin
            rd_mux = ch_rdata[0];
         end
         `SPC_A_CNT1: begin
            rd_mux = ch_rdata[1];
         end
         `SPC_A_CNT2: begin
            rd_mux = ch_rdata[2];
         end
         `SPC_A_SHIFT: begin
            rd_mux = shift_q;
         end
         `SPC_A_GATE: begin
            rd_mux = {6'h00, !irq_en_r, chan_en_r};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // one-cycle registered answer; bus is left alone for unmapped reads
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 8'h00;
         drive_r <= 1'b0;
      end else begin
         drive_r <= io_req.rd && rd_hit;
         rdata_r <= (io_req.rd && rd_hit) ? rd_mux : 8'h00;
      end
   end

   assign io_rdata = rdata_r;
   assign io_rdata_oe_n = !drive_r;

endmodule

// [dv/spc_top_checker.sv]
`timescale 1ns/1ns
`include "spc_map.svh"

module spc_top_checker (
   input wire logic clk,
   input wire logic reset_n,
   input spc_pkg::spc_io_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe_n,
   input wire logic synth_data_oe_n,
   input wire logic synth_write_strobe,
   input wire logic synth_read_strobe,
   input wire logic synth_interrupt_n,
   input wire logic synth_busy_flag,
   input wire logic codec_direction_select,
   input wire logic codec_bit_clock,
   input wire logic codec_byte_frame,
   input wire logic codec_serial_out,
   input wire logic background_flag,
   input wire logic [1:0] rom_page,
   input wire logic [1:0] audio_source_select,
   input wire logic audio_channel_enable,
   input wire logic synth_irq_tick,
   input wire logic audio_test_tone
);
   import spc_pkg::*;
   logic mapped;
   logic mode_set;
   logic shift_wr;
   assign mapped = io_req.addr inside {[`SPC_A_CTRL:`SPC_A_TIMING], [`SPC_A_CNT0:`SPC_A_CNT2],
      `SPC_A_SHIFT, `SPC_A_GATE};
   assign mode_set = io_req.wr && io_req.addr == `SPC_A_MODE && io_req.wdata[7];
   assign shift_wr = io_req.wr && io_req.addr == `SPC_A_SHIFT;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_read_answer: assert property (io_req.rd && mapped |=> !io_rdata_oe_n)
      else $error("mapped read not answered");
   a_unmapped_quiet: assert property (io_req.rd && !mapped |=> io_rdata_oe_n && io_rdata == 8'h00)
      else $error("unmapped read drove the bus");
   a_oe_cause: assert property (!io_rdata_oe_n |-> $past(io_req.rd))
      else $error("data bus driven without a read");
   a_mode_dir: assert property (mode_set |=> synth_data_oe_n == $past(io_req.wdata[1]))
      else $error("synth port direction wrong after mode write");
   a_mode_clear: assert property (mode_set |=> !background_flag && rom_page == 2'h0 &&
      audio_source_select == 2'h0 && !codec_direction_select && !synth_write_strobe &&
      !synth_read_strobe) else $error("port outputs not cleared by mode write");
   a_ctrl_fields: assert property (io_req.wr && io_req.addr == `SPC_A_CTRL |=>
      {background_flag, rom_page, audio_source_select} ==
      {$past(io_req.wdata[7]), $past(io_req.wdata[3:0])}) else $error("control port fields");
   a_timing_fields: assert property (io_req.wr && io_req.addr == `SPC_A_TIMING |=>
      {codec_direction_select, synth_write_strobe, synth_read_strobe} ==
      $past(io_req.wdata[6:4])) else $error("timing port outputs");
   a_timing_read: assert property (io_req.rd && io_req.addr == `SPC_A_TIMING |=>
      io_rdata[3:0] == {~$past(codec_bit_clock), $past(codec_byte_frame),
      $past(synth_interrupt_n), $past(synth_busy_flag)}) else $error("timing port inputs");
   a_gate_read: assert property (io_req.rd && io_req.addr == `SPC_A_GATE |=>
      io_rdata[7:2] == 6'h00 && io_rdata[0] == $past(audio_channel_enable))
      else $error("gating latch read");
   a_irq_steer: assert property (synth_irq_tick |-> !audio_test_tone)
      else $error("interrupt and tone both active");
   a_tone_cause: assert property (audio_test_tone |-> audio_channel_enable &&
      audio_source_select == `SPC_SRC_TEST) else $error("tone without channel and source");
   a_shift_moment: assert property ($changed(codec_serial_out) |-> $fell(codec_bit_clock) ||
      ($past(codec_bit_clock, 2) && !$past(codec_bit_clock)) || $past(shift_wr))
      else $error("serial out moved off edge");
endmodule

bind spc_top spc_top_checker spc_top_checker_inst (.clk, .reset_n, .io_req, .io_rdata,
   .io_rdata_oe_n, .synth_data_oe_n, .synth_write_strobe, .synth_read_strobe,
   .synth_interrupt_n, .synth_busy_flag, .codec_direction_select, .codec_bit_clock,
   .codec_byte_frame, .codec_serial_out, .background_flag, .rom_page, .audio_source_select,
   .audio_channel_enable, .synth_irq_tick, .audio_test_tone);

// [dv/spc_synth_model.sv]
`timescale 1ns/1ns

module spc_synth_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic synth_write_strobe,
   input wire logic synth_read_strobe,
   output logic [7:0] synth_data_in,
   output logic synth_busy_flag,
   output logic synth_interrupt_n
);
   logic ws_d_r, rs_d_r;
   logic [2:0] busy_cnt_r;
   logic [7:0] float_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ws_d_r <= 1'b0;
         rs_d_r <= 1'b0;
         busy_cnt_r <= 3'h0;
         float_r <= 8'h5A;
         synth_interrupt_n <= 1'b1;
      end else begin
         ws_d_r <= synth_write_strobe;
         rs_d_r <= synth_read_strobe;
         float_r <= ~float_r;
         if (synth_write_strobe && !ws_d_r) busy_cnt_r <= 3'h4;
         else if (busy_cnt_r != 3'h0) busy_cnt_r <= busy_cnt_r - 3'h1;
         if (busy_cnt_r == 3'h1) synth_interrupt_n <= 1'b0;
         else if (synth_read_strobe && !rs_d_r) synth_interrupt_n <= 1'b1;
      end
   end
   assign synth_busy_flag = busy_cnt_r != 3'h0;
   // released bus toggles so a stale status can never pass
   assign synth_data_in = synth_read_strobe ?
      {synth_busy_flag, 1'b0, ~synth_busy_flag, 5'h00} : float_r;
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ns
`include "spc_map.svh"

module tb_top;
   import spc_pkg::*;
   typedef struct packed {
      logic [15:0] a;
      logic [7:0] d;
      logic [8:0] obs;
      logic [7:0] rd;
      logic [7:0] m;
   } spc_tb_row_t;
   logic clk, reset_n, codec_serial_in, io_rdata_oe_n, synth_data_oe_n;
   spc_io_req_t io_req;
   logic [7:0] io_rdata, synth_data_in, synth_data_out, rv;
   logic [1:0] rom_page, audio_source_select, sigs;
   logic synth_write_strobe, synth_read_strobe, synth_interrupt_n, synth_busy_flag;
   logic codec_direction_select, codec_bit_clock, codec_byte_frame, codec_serial_out;
   logic background_flag, audio_channel_enable, synth_irq_tick, audio_test_tone;
   logic [8:0] obs;
   int failures = 0, checked = 0, cyc = 0, t, n, k;
   spc_tb_row_t rows [9];
   assign obs = {background_flag, rom_page, audio_source_select, codec_direction_select,
      synth_write_strobe, synth_read_strobe, audio_channel_enable};
   assign sigs = {codec_byte_frame, codec_bit_clock};

   spc_top spc_top_inst (.clk, .reset_n, .io_req, .io_rdata, .io_rdata_oe_n, .synth_data_in,
      .synth_data_out, .synth_data_oe_n, .synth_write_strobe, .synth_read_strobe,
      .synth_interrupt_n, .synth_busy_flag, .codec_direction_select, .codec_bit_clock,
      .codec_byte_frame, .codec_serial_out, .codec_serial_in, .background_flag, .rom_page,
      .audio_source_select, .audio_channel_enable, .synth_irq_tick, .audio_test_tone);
   spc_synth_model spc_synth_model_inst (.clk, .reset_n, .synth_write_strobe,
      .synth_read_strobe, .synth_data_in, .synth_busy_flag, .synth_interrupt_n);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk);
      io_req.wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic io_rd(input logic [15:0] a, input logic oe_n, output logic [7:0] d);
      @(posedge clk);
      io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk);
      io_req.rd <= 1'b0;
      @(negedge clk);
      d = io_rdata;
      chk("rd_oe_n", oe_n, io_rdata_oe_n);
   endtask
   // bounded wait for a level, then for the opposite one gives an edge
   task automatic wait_lvl(input int i, input logic v);
      int w;
      w = 0;
      while (sigs[i] !== v) begin
         @(negedge clk);
         w++;
         if (w > 400) begin
            failures++;
            print_verdict;
         end
      end
   endtask
   task automatic edge_wait(input int i, input logic v);
      wait_lvl(i, !v);
      wait_lvl(i, v);
   endtask
   task automatic count_out;
      n = 0;
      k = 0;
      repeat (40) begin
         @(negedge clk);
         n += int'(synth_irq_tick);
         k += int'(audio_test_tone);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      print_verdict;
   end

   initial begin
      rows = '{'{`SPC_A_CTRL, 8'h00, 9'h000, 8'h00, 8'hFF},
         '{`SPC_A_CTRL, 8'h05, 9'h050, 8'h05, 8'hFF},
         '{`SPC_A_CTRL, 8'h0A, 9'h0A0, 8'h0A, 8'hFF},
         '{`SPC_A_CTRL, 8'h8F, 9'h1F0, 8'h8F, 8'hFF},
         '{`SPC_A_TIMING, 8'h40, 9'h1F8, 8'h40, 8'hF0},
         '{`SPC_A_TIMING, 8'h30, 9'h1F6, 8'h30, 8'hF0},
         '{`SPC_A_GATE, 8'h01, 9'h1F7, 8'h03, 8'hFF},
         '{`SPC_A_GATE, 8'h02, 9'h1F6, 8'h00, 8'hFF},
         '{`SPC_A_GATE, 8'h03, 9'h1F7, 8'h01, 8'hFF}};
      reset_n = 1'b0;
      codec_serial_in = 1'b1;
      io_req = '0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      io_wr(`SPC_A_MODE, `SPC_MODE_NORMAL);
      chk("drive", 1'b0, synth_data_oe_n);
      foreach (rows[i]) begin
         io_wr(rows[i].a, rows[i].d);
         chk("obs", rows[i].obs, obs);
         io_rd(rows[i].a, 1'b0, rv);
         chk("rdback", rows[i].rd & rows[i].m, rv & rows[i].m);
      end
      $display("test rows done");
      io_wr(`SPC_A_MODE, `SPC_MODE_STATUS);
      chk("mode_clr", 9'h001, obs);
      chk("input", 1'b1, synth_data_oe_n);
      io_wr(`SPC_A_MODE, 8'h0B);
      chk("bitset", 1'b1, synth_write_strobe);
      io_wr(`SPC_A_MODE, 8'h0A);
      chk("bitclr", 1'b0, synth_write_strobe);
      io_wr(`SPC_A_MODE, `SPC_MODE_NORMAL);
      io_wr(`SPC_A_CTRL, 8'h04);
      chk("page", 2'h1, rom_page);
      io_wr(`SPC_A_SYNTH, 8'hA5);
      chk("sdata", 8'hA5, synth_data_out);
      io_wr(`SPC_A_TIMING, 8'h20);
      io_rd(`SPC_A_TIMING, 1'b0, rv);
      chk("busy", 5'h05, {rv[7:4], rv[0]});
      io_wr(`SPC_A_TIMING, 8'h00);
      repeat (8) @(negedge clk);
      io_rd(`SPC_A_TIMING, 1'b0, rv);
      chk("irq", 2'h0, rv[1:0]);
      io_wr(`SPC_A_MODE, `SPC_MODE_STATUS);
      io_wr(`SPC_A_TIMING, 8'h10);
      io_rd(`SPC_A_SYNTH, 1'b0, rv);
      chk("status", 3'h1, rv[7:5]);
      io_rd(`SPC_A_TIMING, 1'b0, rv);
      chk("irq_off", 2'h2, rv[1:0]);
      io_wr(`SPC_A_MODE, `SPC_MODE_NORMAL);
      chk("sd_clr", 9'h000, {synth_data_out, synth_read_strobe});
      io_wr(16'hFB90, 8'hFF);
      chk("ignored", 9'h001, obs);
      io_rd(16'hFB90, 1'b1, rv);
      chk("unmapped", 8'h00, rv);
      $display("test ports done");
      io_wr(`SPC_A_SETUP, 8'h36);
      io_wr(`SPC_A_CNT0, 8'h0A);
      io_wr(`SPC_A_CNT0, 8'h00);
      io_wr(`SPC_A_SETUP, 8'h74);
      io_wr(`SPC_A_CNT1, 8'h08);
      io_wr(`SPC_A_CNT1, 8'h00);
      edge_wait(0, 1'b1);
      t = cyc;
      edge_wait(0, 1'b1);
      chk("bitclk", 16'h0A, 16'(cyc - t));
      edge_wait(1, 1'b0);
      t = cyc;
      edge_wait(1, 1'b1);
      chk("frame_lo", 16'h0A, 16'(cyc - t));
      edge_wait(1, 1'b0);
      chk("frame", 16'h50, 16'(cyc - t));
      edge_wait(1, 1'b1);
      io_wr(`SPC_A_SHIFT, 8'hA5);
      chk("ser7", 1'b1, codec_serial_out);
      edge_wait(0, 1'b0);
      @(negedge clk);
      chk("ser6", 1'b0, codec_serial_out);
      io_wr(`SPC_A_TIMING, 8'h40);
      edge_wait(1, 1'b0);
      edge_wait(1, 1'b0);
      io_rd(`SPC_A_SHIFT, 1'b0, rv);
      chk("rec", 8'hFF, rv);
      $display("test codec done");
      io_wr(`SPC_A_GATE, 8'h02);
      io_wr(`SPC_A_CTRL, 8'h02);
      io_wr(`SPC_A_SETUP, 8'hB6);
      io_wr(`SPC_A_CNT2, 8'h06);
      io_wr(`SPC_A_CNT2, 8'h00);
      count_out();
      chk("irq_on", 2'h2, {n > 0 && n < 40, k != 0});
      io_rd(`SPC_A_GATE, 1'b0, rv);
      chk("ie_inv", 8'h00, rv);
      io_wr(`SPC_A_GATE, 8'h01);
      count_out();
      chk("tone_on", 2'h1, {n != 0, k > 0 && k < 40});
      $display("test counter two done");
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      chk("rst", 24'hF00000, {io_rdata_oe_n, synth_data_oe_n, codec_bit_clock,
         codec_byte_frame, obs, synth_data_out, codec_serial_out, synth_irq_tick,
         audio_test_tone});
      repeat (19) @(posedge clk);
      reset_n <= 1'b1;
      io_wr(`SPC_A_MODE, `SPC_MODE_NORMAL);
      chk("drive2", 1'b0, synth_data_oe_n);
      $display("test reset done");
      print_verdict;
   end
endmodule
